// ---- evt_pkg.sv ----
package evt_pkg;
   localparam int FIFO_DEPTH = 32;
   localparam int BYTE_W = 8;
   localparam int LVL_W = 6;
   localparam int REG_W = 16;
   localparam int WM_W = 5;
   localparam int RSN_W = 16;
   localparam logic [31:0] DATA_CMD_ADDR = 32'h5000_1410;
   localparam logic [31:0] RAW_STAT_ADDR = 32'h5000_1434;
   localparam logic [31:0] RX_WM_ADDR = 32'h5000_1438;
   localparam logic [31:0] TX_WM_ADDR = 32'h5000_143C;
   localparam logic [31:0] CLR_ALL_ADDR = 32'h5000_1440;
   localparam logic [31:0] CLR_RDQ_ADDR = 32'h5000_1450;
   localparam logic [31:0] CLR_ABT_ADDR = 32'h5000_1454;
   localparam logic [31:0] ENABLE_ADDR = 32'h5000_146C;
   localparam logic [31:0] STATUS_ADDR = 32'h5000_1470;
   localparam logic [31:0] REASON_ADDR = 32'h5000_1480;
   localparam int BIT_ABORT = 6;
   localparam int BIT_RDREQ = 5;
   localparam int BIT_TXLOW = 4;
   localparam int BIT_TXOVR = 3;
   localparam int BIT_RXHI = 2;
   localparam int BIT_RXOVR = 1;
   localparam int BIT_RXUND = 0;
   localparam int BIT_EN = 0;
   localparam int ST_EN = 0;
   localparam int ST_ACT = 1;
   localparam int ST_TXL_LO = 2;
   localparam int ST_RXL_LO = 8;
   localparam logic [WM_W-1:0] WM_RST = 5'h00;
   localparam logic [WM_W-1:0] WM_MAX = 5'h03;
   localparam logic [LVL_W-1:0] RX_THR_OFS = 6'h01;
   localparam logic [LVL_W-1:0] TX_THR_TOP = 6'h04;
   localparam logic [LVL_W-1:0] FIFO_FULL = 6'h20;
   localparam int LK_W = 30;
   localparam int LK_SCL = 29;
   localparam int LK_ACT = 28;
   localparam int LK_ABT = 27;
   localparam int LK_RSN_LO = 11;
   localparam int LK_RDQ = 10;
   localparam int LK_RXV = 9;
   localparam int LK_RXB_LO = 1;
   localparam int LK_TAKE = 0;
endpackage

// ---- byte_fifo.sv ----
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [LW-1:0] cnt;
   } fifo_state_t;
   fifo_state_t s_r, s_nxt;
   logic push, pop;

   assign in_ready = s_r.cnt != LW'(DEPTH);
   assign out_valid = s_r.cnt != '0;
   assign out_data = s_r.mem[s_r.rp];
   assign level = s_r.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_nxt = s_r;
      if (flush) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
      end else begin
         if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = s_r.wp + 1'b1;
         end
         if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
         end
         if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ---- event_flags.sv ----
// Functional notes
// RULE_01 - Link abort sets transmit abort flag
// RULE_02 - Abort flag holds transmit FIFO flushed
// RULE_03 - Abort reason recorded in reason register
// RULE_04 - Remote read request sets request flag
// RULE_05 - Pending read request holds SCL low
// RULE_06 - Processor answers read request via data
// RULE_07 - Read request clear read drops flag
// RULE_08 - Low-water flag while level at watermark
// RULE_09 - Disabled: flush transmit, low-water follows activity
// RULE_10 - Write to full transmit FIFO: overrun
// RULE_11 - Overrun/underrun flags clear after internal enable
// RULE_12 - High-water flag while level at watermark
// RULE_13 - Disabled: receive flushed, high-water cleared
// RULE_14 - Byte into full receive FIFO: overrun
// RULE_15 - Data read on empty receive: underrun
// RULE_16 - Receive watermark n means n+1
// RULE_17 - Transmit watermark 0..3 means 0..4
// RULE_18 - Abort clear read frees flag, reason
// RULE_19 - Combined clear read clears software flags
// RULE_20 - Raw status read-only, zero after reset
// RULE_21 - Watermark reserved bits zero, ignored
`timescale 1ns/1ps
module event_flags
   import evt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_scl_in,
   input wire logic link_active_in,
   input wire logic link_abort_in,
   input wire logic [RSN_W-1:0] link_reason_in,
   input wire logic link_rd_req_in,
   input wire logic link_rx_valid_in,
   input wire logic [BYTE_W-1:0] link_rx_byte_in,
   input wire logic link_tx_take_in,
   output logic [BYTE_W-1:0] link_tx_byte,
   output logic link_tx_valid,
   output logic scl_out,
   output logic scl_oe
);
   typedef struct packed {
      logic [LK_W-1:0] s1;
      logic [LK_W-1:0] s2;
      logic [LK_W-1:0] s3;
      logic scl_lo;
      logic abort;
      logic rd_req;
      logic tx_over;
      logic rx_over;
      logic rx_under;
      logic [RSN_W-1:0] reason;
      logic enable;
      logic internal_enable_status;
      logic [WM_W-1:0] rx_wm;
      logic [WM_W-1:0] tx_wm;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic rx_had;
      logic [BYTE_W-1:0] tx_byte;
      logic tx_valid;
   } state_t;
   state_t s_r, s_nxt;

   logic [LK_W-1:0] lk_in;
   logic scl_rise, lk_act;
   logic abort_ev, rdq_ev, rxv_ev, take_ev;
   logic setup, acc, wr_acc, rd_acc;
   logic clr_abt, clr_rdq, clr_all, data_rd, data_wr;
   logic [LVL_W-1:0] rx_thr, tx_thr;
   logic tx_low, rx_hi;
   logic [REG_W-1:0] raw;
   logic [31:0] rdval;
   logic unmapped;
   logic tx_flush, tx_in_valid, tx_in_ready, tx_out_valid;
   logic [BYTE_W-1:0] tx_out_data;
   logic [LVL_W-1:0] tx_level;
   logic rx_flush, rx_in_valid, rx_in_ready, rx_out_valid;
   logic [BYTE_W-1:0] rx_out_data;
   logic [LVL_W-1:0] rx_level;

   // Link strobes are sampled only at a settled SCL rise
   // SCL kept inverted so the reset value matches its idle-high level
   assign lk_in = {~link_scl_in, link_active_in, link_abort_in, link_reason_in,
                   link_rd_req_in, link_rx_valid_in, link_rx_byte_in, link_tx_take_in};
   assign scl_rise = (s_r.s2[LK_SCL] == s_r.s3[LK_SCL]) && !s_r.s3[LK_SCL]
                     && s_r.scl_lo;
   assign lk_act = s_r.s3[LK_ACT];
   assign abort_ev = scl_rise && s_r.s3[LK_ABT];
   assign rdq_ev = scl_rise && s_r.s3[LK_RDQ];
   assign rxv_ev = scl_rise && s_r.s3[LK_RXV];
   assign take_ev = scl_rise && s_r.s3[LK_TAKE];

   assign setup = psel && !penable;
   assign acc = psel && penable && s_r.pready;
   assign wr_acc = acc && pwrite;
   assign rd_acc = acc && !pwrite;
   assign clr_abt = rd_acc && (paddr == CLR_ABT_ADDR);
   assign clr_rdq = rd_acc && (paddr == CLR_RDQ_ADDR);
   assign clr_all = rd_acc && (paddr == CLR_ALL_ADDR);
   assign data_rd = rd_acc && (paddr == DATA_CMD_ADDR);
   assign data_wr = wr_acc && (paddr == DATA_CMD_ADDR);

   // Out-of-range watermark values saturate at the top setting
   always_comb begin
      rx_thr = (s_r.rx_wm > WM_MAX ? LVL_W'(WM_MAX) : LVL_W'(s_r.rx_wm))
               + RX_THR_OFS; // RULE_16
      tx_thr = (s_r.tx_wm >= WM_MAX) ? TX_THR_TOP : LVL_W'(s_r.tx_wm); // RULE_17
   end

   assign tx_low = s_r.enable ? (tx_level <= tx_thr) : lk_act; // RULE_08 RULE_09
   assign rx_hi = s_r.enable && (rx_level >= rx_thr); // RULE_12 RULE_13

   always_comb begin
      raw = '0;
      raw[BIT_ABORT] = s_r.abort;
      raw[BIT_RDREQ] = s_r.rd_req;
      raw[BIT_TXLOW] = tx_low;
      raw[BIT_TXOVR] = s_r.tx_over;
      raw[BIT_RXHI] = rx_hi;
      raw[BIT_RXOVR] = s_r.rx_over;
      raw[BIT_RXUND] = s_r.rx_under;
   end

   // Read data is captured in the setup phase so the output is a flop
   always_comb begin
      rdval = '0;
      unmapped = 1'b0;
      unique case (paddr)
         DATA_CMD_ADDR: rdval[BYTE_W-1:0] = rx_out_valid ? rx_out_data : '0;
         RAW_STAT_ADDR: rdval[REG_W-1:0] = raw;
         RX_WM_ADDR: rdval[WM_W-1:0] = s_r.rx_wm; // RULE_21
         TX_WM_ADDR: rdval[WM_W-1:0] = s_r.tx_wm; // RULE_21
         CLR_ALL_ADDR, CLR_RDQ_ADDR, CLR_ABT_ADDR: rdval = '0;
         ENABLE_ADDR: rdval[BIT_EN] = s_r.enable;
         STATUS_ADDR: begin
            rdval[ST_EN] = s_r.internal_enable_status;
            rdval[ST_ACT] = lk_act;
            rdval[ST_TXL_LO +: LVL_W] = tx_level;
            rdval[ST_RXL_LO +: LVL_W] = rx_level;
         end
         REASON_ADDR: rdval[RSN_W-1:0] = s_r.reason;
         default: unmapped = 1'b1;
      endcase
   end

   assign tx_flush = !s_r.enable || s_r.abort; // RULE_02 RULE_09
   assign tx_in_valid = data_wr && !tx_flush;
   assign rx_flush = !s_r.enable; // RULE_13
   assign rx_in_valid = rxv_ev && s_r.enable;

   byte_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) tx_fifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .flush(tx_flush),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .in_data(pwdata[BYTE_W-1:0]),
      .out_valid(tx_out_valid),
      .out_ready(take_ev),
      .out_data(tx_out_data),
      .level(tx_level)
   );

   byte_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) rx_fifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .flush(rx_flush),
      .in_valid(rx_in_valid),
      .in_ready(rx_in_ready),
      .in_data(s_r.s3[LK_RXB_LO +: BYTE_W]),
      .out_valid(rx_out_valid),
      .out_ready(data_rd && s_r.rx_had),
      .out_data(rx_out_data),
      .level(rx_level)
   );

   always_comb begin
      s_nxt = s_r;
      // Stage one feeds only stage two
      s_nxt.s1 = lk_in;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      if (s_r.s2[LK_SCL] == s_r.s3[LK_SCL]) begin
         s_nxt.scl_lo = s_r.s3[LK_SCL];
      end
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = setup && unmapped;
      if (setup) begin
         s_nxt.prdata = rdval;
         s_nxt.rx_had = rx_out_valid;
      end
      if (wr_acc) begin
         // Raw status and clear registers ignore writes
         unique case (paddr)
            RX_WM_ADDR: s_nxt.rx_wm = pwdata[WM_W-1:0]; // RULE_21
            TX_WM_ADDR: s_nxt.tx_wm = pwdata[WM_W-1:0]; // RULE_21
            ENABLE_ADDR: s_nxt.enable = pwdata[BIT_EN];
            default: s_nxt.enable = s_r.enable; // RULE_20
         endcase
      end
      // Engine stays on until the bus goes idle after disable
      s_nxt.internal_enable_status = s_r.enable || (s_r.internal_enable_status && lk_act);
      // Clears first, so a same-cycle set wins
      if (clr_abt || clr_all) begin
         s_nxt.abort = 1'b0; // RULE_18 RULE_19
         s_nxt.reason = '0; // RULE_18 RULE_19
      end
      if (clr_rdq || clr_all) begin
         s_nxt.rd_req = 1'b0; // RULE_07 RULE_19
      end
      if (clr_all) begin
         s_nxt.tx_over = 1'b0; // RULE_19
         s_nxt.rx_over = 1'b0; // RULE_19
         s_nxt.rx_under = 1'b0; // RULE_19
      end
      if (!s_r.enable && !s_r.internal_enable_status) begin
         s_nxt.tx_over = 1'b0; // RULE_11
         s_nxt.rx_over = 1'b0; // RULE_11
         s_nxt.rx_under = 1'b0; // RULE_11
      end
      if (abort_ev) begin
         s_nxt.abort = 1'b1; // RULE_01
         s_nxt.reason = s_nxt.reason | s_r.s3[LK_RSN_LO +: RSN_W]; // RULE_03
      end
      if (rdq_ev) begin
         s_nxt.rd_req = 1'b1; // RULE_04
      end
      if (data_wr && !tx_flush && !tx_in_ready) begin
         s_nxt.tx_over = 1'b1; // RULE_10
      end
      if (rx_in_valid && !rx_in_ready) begin
         s_nxt.rx_over = 1'b1; // RULE_14
      end
      if (data_rd && !s_r.rx_had) begin
         s_nxt.rx_under = 1'b1; // RULE_15
      end
      s_nxt.tx_valid = take_ev && tx_out_valid;
      if (take_ev && tx_out_valid) begin
         s_nxt.tx_byte = tx_out_data;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0; // RULE_20
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign link_tx_byte = s_r.tx_byte;
   assign link_tx_valid = s_r.tx_valid;
   // Open-drain: only ever pulls low
   assign scl_out = 1'b0;
   assign scl_oe = s_r.rd_req; // RULE_05

   abort_set_a: assert property ( // RULE_01
      @(posedge ref_clk) disable iff (!reset_n)
      abort_ev |=> s_r.abort)
      else $error("abort event did not set flag");

   tx_flushed_a: assert property ( // RULE_02
      @(posedge ref_clk) disable iff (!reset_n)
      s_r.abort && $past(s_r.abort) |-> tx_level == '0 && !tx_in_valid)
      else $error("transmit FIFO not held flushed on abort");

   reason_rec_a: assert property ( // RULE_03
      @(posedge ref_clk) disable iff (!reset_n)
      abort_ev |=> (s_r.reason & $past(s_r.s3[LK_RSN_LO +: RSN_W]))
                   == $past(s_r.s3[LK_RSN_LO +: RSN_W]))
      else $error("abort reason not recorded");

   rdreq_hold_a: assert property ( // RULE_05
      @(posedge ref_clk) disable iff (!reset_n)
      rdq_ev ##1 !(clr_rdq || clr_all) |-> (scl_oe && !scl_out) [*2])
      else $error("SCL not held low on read request");

   rdreq_clr_a: assert property ( // RULE_07
      @(posedge ref_clk) disable iff (!reset_n)
      clr_rdq && !rdq_ev |=> !s_r.rd_req)
      else $error("read request flag not cleared");

   tx_low_a: assert property ( // RULE_08
      @(posedge ref_clk) disable iff (!reset_n)
      setup && paddr == RAW_STAT_ADDR && s_r.enable
      |=> s_r.prdata[BIT_TXLOW] == ($past(tx_level) <= $past(tx_thr)))
      else $error("low-water flag wrong");

   tx_over_a: assert property ( // RULE_10
      @(posedge ref_clk) disable iff (!reset_n)
      data_wr && !tx_flush && tx_level == FIFO_FULL |=> s_r.tx_over)
      else $error("transmit overrun not flagged");

   ovr_keep_a: assert property ( // RULE_11
      @(posedge ref_clk) disable iff (!reset_n)
      !s_r.enable && s_r.internal_enable_status && s_r.rx_over && !clr_all |=> s_r.rx_over)
      else $error("receive overrun dropped before idle");

   rx_hi_a: assert property ( // RULE_12
      @(posedge ref_clk) disable iff (!reset_n)
      setup && paddr == RAW_STAT_ADDR && s_r.enable
      && rx_level == LVL_W'(s_r.rx_wm) + RX_THR_OFS && s_r.rx_wm <= WM_MAX
      |=> s_r.prdata[BIT_RXHI])
      else $error("high-water flag missing at watermark");

   rx_flush_a: assert property ( // RULE_13
      @(posedge ref_clk) disable iff (!reset_n)
      $fell(s_r.enable) |=> rx_level == '0 && !rx_hi)
      else $error("receive FIFO not flushed on disable");

   rx_over_a: assert property ( // RULE_14
      @(posedge ref_clk) disable iff (!reset_n)
      rxv_ev && s_r.enable && rx_level == FIFO_FULL && !data_rd
      |=> s_r.rx_over && rx_level == FIFO_FULL)
      else $error("receive overrun not flagged");

   rx_under_a: assert property ( // RULE_15
      @(posedge ref_clk) disable iff (!reset_n)
      setup && paddr == DATA_CMD_ADDR && !rx_out_valid && !pwrite
      ##1 penable |=> s_r.rx_under)
      else $error("receive underrun not flagged");

   abort_clr_a: assert property ( // RULE_18
      @(posedge ref_clk) disable iff (!reset_n)
      clr_abt && !abort_ev |=> !s_r.abort && s_r.reason == '0)
      else $error("abort clear read ineffective");
endmodule

// ---- link_partner.sv ----
`timescale 1ns/1ps
module link_partner
   import evt_pkg::*;
(
   output logic scl,
   output logic active,
   output logic abort,
   output logic [RSN_W-1:0] reason,
   output logic rd_req,
   output logic rx_valid,
   output logic [BYTE_W-1:0] rx_byte,
   output logic take,
   input wire logic scl_oe,
   input wire logic scl_val
);
   logic drv;
   // Wired level: a stretching slave wins over our clock
   assign scl = drv & ~(scl_oe & ~scl_val);
   initial begin
      drv = 1'b1;
      active = 1'b0;
      abort = 1'b0;
      reason = 16'h0000;
      rd_req = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      take = 1'b0;
   end
   task automatic busy(input logic a);
      active = a;
   endtask
   // One 160 ns link clock; SCL idles high between frames
   task automatic beat(input logic [3:0] ev, input logic [7:0] b, input logic [15:0] r);
      drv = 1'b0;
      {take, abort, rd_req, rx_valid} = ev;
      rx_byte = b;
      reason = r;
      #80;
      drv = 1'b1;
      #80;
      // Released lines show garbage, never the old value
      {take, abort, rd_req, rx_valid} = 4'h0;
      rx_byte = ~b;
      reason = ~r;
   endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import evt_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic scl, act, abt, rdq, rxv, take, tx_valid, scl_oe, scl_pull;
   logic [15:0] rsn;
   logic [7:0] rxb, tx_byte, last_tx;
   int fails = 0;
   int checked = 0;

   always #5 ref_clk = ~ref_clk;
   // Pulse lasts one cycle, so latch it here
   always @(posedge ref_clk) if (tx_valid === 1'b1) last_tx <= tx_byte;

   event_flags dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_scl_in(scl), .link_active_in(act), .link_abort_in(abt),
      .link_reason_in(rsn), .link_rd_req_in(rdq), .link_rx_valid_in(rxv),
      .link_rx_byte_in(rxb), .link_tx_take_in(take), .link_tx_byte(tx_byte),
      .link_tx_valid(tx_valid), .scl_out(scl_pull), .scl_oe(scl_oe));
   link_partner lp (.scl(scl), .active(act), .abort(abt), .reason(rsn), .rd_req(rdq),
      .rx_valid(rxv), .rx_byte(rxb), .take(take), .scl_oe(scl_oe), .scl_val(scl_pull));

   task automatic complete_run();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Request held through the ready edge; answer taken at that same edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      #1;
      psel = 1'b1;
      pwrite = w;
      paddr = a;
      pwdata = d;
      @(posedge ref_clk);
      #1;
      penable = 1'b1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 8) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 8) begin
         fails++;
         complete_run();
      end else begin
         rd = prdata;
         err = pslverr;
         #1;
         psel = 1'b0;
         penable = 1'b0;
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg_%h", a), e, rd);
   endtask

   task automatic flag(input int b, input logic e);
      xfer(1'b0, RAW_STAT_ADDR, 32'h0);
      chk($sformatf("flag_%0d", b), 32'(e), 32'(rd[b]));
   endtask

   task automatic lvl(input int t, input int r);
      xfer(1'b0, STATUS_ADDR, 32'h0);
      chk("tx_level", t, 32'(rd[ST_TXL_LO +: LVL_W]));
      chk("rx_level", r, 32'(rd[ST_RXL_LO +: LVL_W]));
   endtask

   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (4) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      rdchk(RAW_STAT_ADDR, 32'h0);
      wr(RAW_STAT_ADDR, 32'hFFFF);
      rdchk(RAW_STAT_ADDR, 32'h0);
      rdchk(RX_WM_ADDR, 32'h0);
      wr(RX_WM_ADDR, 32'hFFFF);
      rdchk(RX_WM_ADDR, 32'h1F);
      xfer(1'b0, 32'h5000_14FC, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      // Transmit watermark: thresholds 0, 1, 2, 4
      for (int w = 0; w < 4; w++) begin
         wr(ENABLE_ADDR, 32'h0);
         wr(ENABLE_ADDR, 32'h1);
         wr(TX_WM_ADDR, 32'(w));
         for (int l = 0; l < 6; l++) begin
            flag(BIT_TXLOW, l <= ((w == 3) ? 4 : w));
            wr(DATA_CMD_ADDR, 32'(l));
         end
      end
      wr(ENABLE_ADDR, 32'h0);
      flag(BIT_TXLOW, 1'b0);
      lvl(0, 0);
      wr(ENABLE_ADDR, 32'h1);
      for (int i = 0; i < 32; i++) wr(DATA_CMD_ADDR, 32'(i));
      flag(BIT_TXOVR, 1'b0);
      wr(DATA_CMD_ADDR, 32'hEE);
      flag(BIT_TXOVR, 1'b1);
      lvl(32, 0);
      lp.beat(4'h8, 8'h00, 16'h0000);
      chk("tx_byte", 32'h0, 32'(last_tx));
      lvl(31, 0);
      // Disable while the engine is still busy
      lp.busy(1'b1);
      repeat (10) @(posedge ref_clk);
      wr(ENABLE_ADDR, 32'h0);
      flag(BIT_TXOVR, 1'b1);
      flag(BIT_TXLOW, 1'b1);
      lvl(0, 0);
      lp.busy(1'b0);
      repeat (10) @(posedge ref_clk);
      flag(BIT_TXOVR, 1'b0);
      flag(BIT_TXLOW, 1'b0);
      // Receive watermark: n means n+1 entries
      for (int w = 0; w < 4; w++) begin
         wr(ENABLE_ADDR, 32'h0);
         wr(ENABLE_ADDR, 32'h1);
         wr(RX_WM_ADDR, 32'(w));
         for (int l = 0; l <= w + 1; l++) begin
            if (l > 0) lp.beat(4'h1, 8'(l), 16'h0000);
            flag(BIT_RXHI, l > w);
         end
      end
      rdchk(DATA_CMD_ADDR, 32'h1);
      flag(BIT_RXHI, 1'b0);
      wr(RX_WM_ADDR, 32'h0);
      flag(BIT_RXHI, 1'b1);
      lp.busy(1'b1);
      wr(ENABLE_ADDR, 32'h0);
      flag(BIT_RXHI, 1'b0);
      lvl(0, 0);
      lp.busy(1'b0);
      repeat (10) @(posedge ref_clk);
      wr(ENABLE_ADDR, 32'h1);
      for (int i = 0; i < 32; i++) lp.beat(4'h1, 8'(i), 16'h0000);
      flag(BIT_RXOVR, 1'b0);
      lp.beat(4'h1, 8'hEE, 16'h0000);
      flag(BIT_RXOVR, 1'b1);
      lvl(0, 32);
      for (int i = 0; i < 32; i++) rdchk(DATA_CMD_ADDR, 32'(i));
      flag(BIT_RXUND, 1'b0);
      xfer(1'b0, DATA_CMD_ADDR, 32'h0);
      flag(BIT_RXUND, 1'b1);
      xfer(1'b0, CLR_ALL_ADDR, 32'h0);
      // Empty transmit FIFO keeps the hardware low-water flag up
      rdchk(RAW_STAT_ADDR, 32'h10);
      // Remote read request stretches the clock
      lp.beat(4'h2, 8'h00, 16'h0000);
      flag(BIT_RDREQ, 1'b1);
      chk("scl_held", 32'h1, 32'({scl_oe, scl} == 2'b10));
      wr(DATA_CMD_ADDR, 32'hA5);
      xfer(1'b0, CLR_RDQ_ADDR, 32'h0);
      flag(BIT_RDREQ, 1'b0);
      chk("scl_oe", 32'h0, 32'(scl_oe));
      lp.beat(4'h8, 8'h00, 16'h0000);
      chk("tx_byte", 32'hA5, 32'(last_tx));
      // Abort flushes and locks the transmit path
      wr(DATA_CMD_ADDR, 32'h11);
      wr(DATA_CMD_ADDR, 32'h22);
      lvl(2, 0);
      lp.beat(4'h4, 8'h00, 16'h0025);
      flag(BIT_ABORT, 1'b1);
      rdchk(REASON_ADDR, 32'h25);
      lvl(0, 0);
      wr(DATA_CMD_ADDR, 32'h33);
      lvl(0, 0);
      xfer(1'b0, CLR_ABT_ADDR, 32'h0);
      flag(BIT_ABORT, 1'b0);
      rdchk(REASON_ADDR, 32'h0);
      wr(DATA_CMD_ADDR, 32'h44);
      lvl(1, 0);
      lp.beat(4'h4, 8'h00, 16'h0003);
      flag(BIT_ABORT, 1'b1);
      xfer(1'b0, CLR_ALL_ADDR, 32'h0);
      flag(BIT_ABORT, 1'b0);
      rdchk(REASON_ADDR, 32'h0);
      complete_run();
   end
endmodule
